// File: rtl/dark_cal_consts.svh
// Register map, field positions, reset values and counts for dark-level calibration
// ----------------------------------------------------------------------------
// Summary of operation
// - Generate programmed dark rows each frame start
// - Global shutter dark rows hold 240 kernels
// - Rolling shutter dark row follows window
// - Calibrate each of eight kernel columns
// - Skip bit blanks and excludes first row
// - Auto mode corrects pixels from dark level
// - Manual mode adds or subtracts signed offset
// - Auto mode ignores manual sign bit
// - Manual offset is common to all columns
// - Dark samples leave the block raw, blanked first row as zero
// - Auto mode recomputes factors every frame unless frozen
// - All-ones offset freezes factors in auto
// - Filter averages two-power-of-field dark samples
// - Per-path error flags on sample shortfall
// - Correct toward target, clip below zero
// - Unsynced dark-row count keeps previous value
// ----------------------------------------------------------------------------
`ifndef DARK_CAL_CONSTS_SVH
`define DARK_CAL_CONSTS_SVH

`define FILT_CFG_ADDR 9'h080
`define OFS_CTRL_ADDR 9'h081
`define SHORT_ADDR 9'h088
`define ROW_CFG_ADDR 9'h0C5

`define FILT_CFG_RST 16'h0000
`define OFS_CTRL_RST 16'h0000
`define ROW_CFG_RST 16'h0008

`define SAMP_EXP_LSB 8
`define AUTO_EN_BIT 0
`define OFS_LSB 1
`define OFS_SIGN_BIT 10
`define GATE_FIRST_BIT 8

`define OFS_FREEZE 9'h1FF
`define GS_ROW_KERNELS 8'd240

`endif

// File: rtl/dark_cal_pkg.sv
// Types shared by the dark-level calibration modules
package dark_cal_pkg;
  typedef enum logic [1:0] {IDLE_ST, DARK_ST, IMAGE_ST} cal_state_e;
  typedef logic [15:0] reg_word_t;
endpackage

// File: rtl/dark_filter_if.sv
// Carrier between frame control and the per-column dark filter
`timescale 1ns/1ps
interface dark_filter_if #(parameter int KW = 8, parameter int PW = 10);
  logic clear;
  logic sample_valid;
  logic [KW*PW-1:0] samples;
  logic [2:0] nexp;
  logic [KW*PW-1:0] level;
  logic [KW-1:0] shortfall;
  modport ctrl (output clear, output sample_valid, output samples, output nexp,
                input level, input shortfall);
  modport filt (input clear, input sample_valid, input samples, input nexp,
                output level, output shortfall);
endinterface

// File: rtl/dark_filter.sv
// Per-column dark sample averaging filter
`timescale 1ns/1ps
`include "dark_cal_consts.svh"
module dark_filter
  import dark_cal_pkg::*;
#(
  parameter int KW = 8,
  parameter int PW = 10
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  dark_filter_if.filt fif // Samples in, levels out
);
  localparam int SW = PW + 7;

  logic [SW-1:0] sum_reg [KW];
  logic [7:0] cnt_reg [KW];
  logic [8:0] need;
  logic [KW-1:0] take;

  // Sample count is a power of two so the average is a plain shift
  assign need = 9'd1 << fif.nexp;

  // ----------------------------------------------------------------------
  // Accumulators, one per kernel column
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < KW; c++) begin : g_col
    logic [SW-1:0] sum_now;
    assign take[c] = fif.sample_valid && ({1'b0, cnt_reg[c]} < need);
    assign sum_now = sum_reg[c] + (take[c] ? SW'(fif.samples[c*PW +: PW]) : SW'(0));
    always_ff @(posedge mclk) begin
      if (rst || fif.clear) begin
        sum_reg[c] <= '0;
        cnt_reg[c] <= '0;
      end else if (take[c]) begin
        sum_reg[c] <= sum_now;
        cnt_reg[c] <= cnt_reg[c] + 8'd1;
      end
    end
    // Results include the sample arriving this cycle, so a read on the
    // edge of the last dark kernel does not lose that kernel
    assign fif.level[c*PW +: PW] = PW'(sum_now >> fif.nexp);
    assign fif.shortfall[c] = ({1'b0, cnt_reg[c]} + 9'(take[c])) < need;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_count_limit: assert property (
    ({1'b0, cnt_reg[0]} <= need) || $changed(fif.nexp))
    else $error("filter took more samples than requested");
endmodule // dark_filter

// File: rtl/dark_level_calibration.sv
// Dark-row generation, dark-level calibration and pixel offset correction
`timescale 1ns/1ps
`include "dark_cal_consts.svh"
module dark_level_calibration
  import dark_cal_pkg::*;
#(
  parameter int KW = 8,
  parameter int PW = 10
) (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [8:0] reg_addr, // Register index
  input wire logic reg_wr, // Register write strobe
  input wire logic [15:0] reg_wdata, // Register write data
  output logic [15:0] reg_rdata, // Register read data, one cycle late
  input wire logic frame_start, // Frame start pulse
  input wire logic rolling_shutter, // 1: rolling shutter readout
  input wire logic [7:0] win_kernels, // Kernels in active window row
  input wire logic sync_dark_rows, // Take new dark-row count at frame start
  input wire logic [PW-1:0] dark_target, // Target dark level
  input wire logic in_valid, // Kernel valid from readout
  input wire logic [KW*PW-1:0] in_data, // Kernel of pixels
  output logic out_valid, // Kernel valid out
  output logic [KW*PW-1:0] out_data, // Kernel out
  output logic out_dark, // Kernel is a dark row sample
  output logic out_blank // Kernel belongs to a blanked dark row
);
  cal_state_e state_reg;
  reg_word_t filt_cfg_reg, ofs_ctrl_reg, row_cfg_reg;
  logic [7:0] rows_act_reg;
  logic [7:0] row_cnt_reg, kern_cnt_reg;
  logic [KW*PW-1:0] level_reg;
  logic [KW-1:0] short_reg;
  logic [7:0] row_len;
  logic kern_last, row_last, end_dark, gate_row, auto_en, frozen;
  logic [8:0] man_ofs;

  dark_filter_if #(.KW(KW), .PW(PW)) fif ();

  dark_filter #(.KW(KW), .PW(PW)) u_filter (
    .mclk(mclk),
    .rst(rst),
    .fif(fif)
  );

  // Clip to the pixel range; negative results clip to zero
  // High side clips too, so a large target cannot wrap a bright pixel
  function automatic logic [PW-1:0] pix_fix(input logic [PW-1:0] p,
                                            input logic signed [PW+1:0] d);
    logic signed [PW+2:0] s;
    s = $signed({3'b000, p}) + $signed({d[PW+1], d});
    if (s < 0) begin
      pix_fix = '0;
    end else if (s > $signed((PW+3)'((1 << PW) - 1))) begin
      pix_fix = '1;
    end else begin
      pix_fix = s[PW-1:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_cfg_reg <= `FILT_CFG_RST;
      ofs_ctrl_reg <= `OFS_CTRL_RST;
      row_cfg_reg <= `ROW_CFG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `FILT_CFG_ADDR: filt_cfg_reg <= reg_wdata;
        `OFS_CTRL_ADDR: ofs_ctrl_reg <= reg_wdata;
        `ROW_CFG_ADDR: row_cfg_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Status reads give the flags of the last frame; writes to them are dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        `FILT_CFG_ADDR: reg_rdata <= filt_cfg_reg;
        `OFS_CTRL_ADDR: reg_rdata <= ofs_ctrl_reg;
        `SHORT_ADDR: reg_rdata <= 16'(short_reg);
        `ROW_CFG_ADDR: reg_rdata <= row_cfg_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  assign auto_en = ofs_ctrl_reg[`AUTO_EN_BIT];
  assign man_ofs = ofs_ctrl_reg[`OFS_LSB +: 9];
  assign frozen = auto_en && man_ofs == `OFS_FREEZE;

  // ----------------------------------------------------------------------
  // Dark row sequencing
  // ----------------------------------------------------------------------
  // Rolling rows follow the window; global rows are fixed width
  assign row_len = rolling_shutter ? win_kernels : `GS_ROW_KERNELS;
  assign kern_last = kern_cnt_reg == row_len - 8'd1;
  // A count of 0 wraps to 256 rows; the host must keep it in 1 to 255
  assign row_last = row_cnt_reg == rows_act_reg - 8'd1;
  assign end_dark = state_reg == DARK_ST && in_valid && kern_last && row_last;
  assign gate_row = row_cfg_reg[`GATE_FIRST_BIT] && row_cnt_reg == 8'd0;

  // The count only moves at frame start, so a write mid-frame cannot
  // cut short the dark rows already running
  always_ff @(posedge mclk) begin
    if (rst) begin
      rows_act_reg <= 8'(`ROW_CFG_RST);
    end else if (frame_start && sync_dark_rows) begin
      rows_act_reg <= row_cfg_reg[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= IDLE_ST;
    end else if (frame_start) begin
      state_reg <= DARK_ST;
    end else begin
      case (state_reg)
        DARK_ST: if (end_dark) state_reg <= IMAGE_ST;
        IMAGE_ST: state_reg <= IMAGE_ST;
        IDLE_ST: state_reg <= IDLE_ST;
        default: state_reg <= IDLE_ST;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || frame_start) begin
      row_cnt_reg <= '0;
      kern_cnt_reg <= '0;
    end else if (state_reg == DARK_ST && in_valid) begin
      if (kern_last) begin
        kern_cnt_reg <= '0;
        row_cnt_reg <= row_cnt_reg + 8'd1;
      end else begin
        kern_cnt_reg <= kern_cnt_reg + 8'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Filter feed and factor update
  // ----------------------------------------------------------------------
  assign fif.clear = frame_start;
  assign fif.sample_valid = state_reg == DARK_ST && in_valid && !gate_row;
  assign fif.samples = in_data;
  assign fif.nexp = filt_cfg_reg[`SAMP_EXP_LSB +: 3];

  // Levels are taken on the edge of the last dark kernel, so the first
  // image kernel right behind it is already corrected with them
  always_ff @(posedge mclk) begin
    if (rst) begin
      level_reg <= '0;
    end else if (end_dark && auto_en && !frozen) begin
      level_reg <= fif.level;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      short_reg <= '0;
    end else if (end_dark) begin
      short_reg <= fif.shortfall;
    end
  end

  // ----------------------------------------------------------------------
  // Pixel output
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_dark <= 1'b0;
      out_blank <= 1'b0;
    end else begin
      out_valid <= in_valid && state_reg != IDLE_ST;
      out_dark <= in_valid && state_reg == DARK_ST;
      out_blank <= in_valid && state_reg == DARK_ST && gate_row;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_data <= '0;
    end else if (in_valid && state_reg == DARK_ST) begin
      out_data <= gate_row ? '0 : in_data;
    end else if (in_valid && state_reg == IMAGE_ST) begin
      for (int c = 0; c < KW; c++) begin
        if (auto_en) begin
          out_data[c*PW +: PW] <= pix_fix(in_data[c*PW +: PW],
            $signed({2'b00, dark_target}) - $signed({2'b00, level_reg[c*PW +: PW]}));
        end else if (ofs_ctrl_reg[`OFS_SIGN_BIT]) begin
          out_data[c*PW +: PW] <= pix_fix(in_data[c*PW +: PW], -$signed({3'b000, man_ofs}));
        end else begin
          out_data[c*PW +: PW] <= pix_fix(in_data[c*PW +: PW], $signed({3'b000, man_ofs}));
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_last_kernel;
    state_reg == DARK_ST && in_valid && kern_last && row_last && !frame_start;
  endsequence

  sequence s_take_levels;
    end_dark && auto_en && !frozen;
  endsequence

  sequence s_row_reload;
    frame_start && sync_dark_rows;
  endsequence

  sequence s_kernel_in;
    in_valid && state_reg != IDLE_ST;
  endsequence

  sequence s_gs_row_end;
    state_reg == DARK_ST && !rolling_shutter && in_valid
    && kern_cnt_reg == `GS_ROW_KERNELS - 8'd1 && !frame_start;
  endsequence

  sequence s_below_zero;
    state_reg == IMAGE_ST && in_valid && !auto_en && ofs_ctrl_reg[`OFS_SIGN_BIT]
    && in_data[PW-1:0] < PW'(man_ofs);
  endsequence

  a_rows_then_image: assert property (
    s_last_kernel |=> state_reg == IMAGE_ST)
    else $error("dark rows did not end after programmed count");
  a_gs_row_len: assert property (
    state_reg == DARK_ST && !rolling_shutter |-> kern_cnt_reg < 8'd240)
    else $error("global shutter dark row exceeds 240 kernels");
  a_rs_row_len: assert property (
    state_reg == DARK_ST && rolling_shutter && in_valid && kern_cnt_reg == win_kernels - 8'd1
    && !frame_start |=> kern_cnt_reg == 8'd0)
    else $error("rolling dark row did not follow window length");
  a_gate_first: assert property (
    state_reg == DARK_ST && in_valid && gate_row |-> !fif.sample_valid ##1 out_blank)
    else $error("first dark row not blanked");
  a_dark_raw: assert property (
    state_reg == DARK_ST && in_valid && !gate_row |=> out_dark && out_data == $past(in_data))
    else $error("dark sample was altered");
  a_manual_add: assert property (
    state_reg == IMAGE_ST && in_valid && !frame_start && !auto_en && !ofs_ctrl_reg[`OFS_SIGN_BIT]
    && in_data[PW-1:0] == '0 && man_ofs < 9'd300 |=> out_data[PW-1:0] == PW'($past(man_ofs)))
    else $error("manual offset not added");
  a_freeze_hold: assert property (
    frozen |=> $stable(level_reg))
    else $error("factors changed while frozen");
  a_short_update: assert property (
    end_dark |=> short_reg == $past(fif.shortfall))
    else $error("shortfall flags not taken at end of dark rows");
  a_sync_hold: assert property (
    !sync_dark_rows |=> $stable(rows_act_reg))
    else $error("dark row count changed while unsynced");

  // ----------------------------------------------------------------------
  // Factor, flag and stream checks
  // ----------------------------------------------------------------------
  a_levels_taken: assert property (
    s_take_levels |=> level_reg == $past(fif.level))
    else $error("calculated dark levels not taken at end of dark rows");
  a_manual_keeps: assert property (
    !auto_en |=> $stable(level_reg))
    else $error("dark levels changed in manual mode");
  a_row_reload: assert property (
    s_row_reload |=> rows_act_reg == $past(row_cfg_reg[7:0]))
    else $error("dark row count not reloaded at frame start");
  a_kernel_out: assert property (
    s_kernel_in |=> out_valid)
    else $error("kernel was not passed on");
  a_no_stray: assert property (
    !in_valid |=> !out_valid)
    else $error("output valid without input kernel");
  a_gs_row_wrap: assert property (
    s_gs_row_end |=> kern_cnt_reg == 8'd0)
    else $error("global shutter dark row did not end at 240 kernels");
  a_clip_zero: assert property (
    s_below_zero |=> out_data[PW-1:0] == '0)
    else $error("negative pixel not clipped to zero");
  a_short_hold: assert property (
    !end_dark |=> $stable(short_reg))
    else $error("shortfall flags changed outside frame update");
  a_blank_zero: assert property (
    out_blank |-> out_data == '0)
    else $error("blanked dark row carried data");
  a_image_mark: assert property (
    state_reg == IMAGE_ST && in_valid |=> out_valid && !out_dark)
    else $error("image kernel not marked as image");
endmodule // dark_level_calibration

// File: sim/pixel_source.sv
// Pixel readout source model feeding kernels to the calibration block
`timescale 1ns/1ps
module pixel_source #(
  parameter int W = 80
) (
  input wire logic mclk, // System clock
  output logic frame_start, // Frame start pulse
  output logic in_valid, // Kernel valid
  output logic [W-1:0] in_data // Kernel pixels
);
  initial begin
    frame_start = 1'b0;
    in_valid = 1'b0;
    in_data = '0;
  end
  // Dark kernels come first, then image kernels; gap models a slow readout
  task automatic send_frame(input int nd, input int ni, input logic [W-1:0] dp,
                            input logic [W-1:0] ip, input int gap);
    @(negedge mclk);
    frame_start = 1'b1;
    @(negedge mclk);
    frame_start = 1'b0;
    for (int k = 0; k < nd + ni; k++) begin
      in_valid = 1'b1;
      in_data = (k < nd) ? dp : ip;
      @(negedge mclk);
      if (gap > 0) begin
        in_valid = 1'b0;
        in_data = ~in_data; // Idle bus never repeats the last kernel
        repeat (gap) @(negedge mclk);
      end
    end
    in_valid = 1'b0;
    in_data = ~in_data;
  endtask
endmodule // pixel_source

// File: sim/tb.sv
// Self-checking bench for dark-level calibration
`timescale 1ns/1ps
`include "dark_cal_consts.svh"
module tb;
  import dark_cal_pkg::*;
  logic mclk, rst, reg_wr, rolling_shutter, sync_dark_rows, frame_start, in_valid;
  logic out_valid, out_dark, out_blank;
  logic [8:0] reg_addr;
  reg_word_t reg_wdata, reg_rdata;
  logic [7:0] win_kernels;
  logic [9:0] dark_target;
  logic [79:0] in_data, out_data, exp_img, exp_dark;
  int fails = 0;
  int n_tests = 0;
  int n_dark, n_blank, n_img;

  dark_level_calibration u_dark_level_calibration (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .rolling_shutter(rolling_shutter),
    .win_kernels(win_kernels), .sync_dark_rows(sync_dark_rows), .dark_target(dark_target),
    .in_valid(in_valid), .in_data(in_data), .out_valid(out_valid), .out_data(out_data),
    .out_dark(out_dark), .out_blank(out_blank));
  pixel_source u_pixel_source (.mclk(mclk), .frame_start(frame_start),
    .in_valid(in_valid), .in_data(in_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [79:0] cv(input int b, input int s);
    for (int c = 0; c < 8; c++) cv[c*10+:10] = 10'(b + s * c);
  endfunction

  task automatic chk(input string name, input logic [79:0] exp, input logic [79:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input reg_word_t d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input reg_word_t exp);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    chk("reg_rdata", {64'h0, exp}, {64'h0, reg_rdata});
  endtask

  task automatic frame(input int nd, input logic [79:0] dp, input logic [79:0] ip,
                       input int gap, input int xb);
    exp_dark = dp;
    n_dark = 0;
    n_blank = 0;
    n_img = 0;
    u_pixel_source.send_frame(nd, 4, dp, ip, gap);
    repeat (3) @(negedge mclk);
    chk("dark_kernels", 80'(nd), 80'(n_dark));
    chk("blank_kernels", 80'(xb), 80'(n_blank));
    chk("image_kernels", 80'd4, 80'(n_img));
  endtask

  // Dark kernels leave raw (blanked ones as zero), image kernels corrected
  always @(negedge mclk) begin
    if (!rst && out_valid === 1'b1) begin
      if (out_dark === 1'b1) begin
        n_dark++;
        if (out_blank === 1'b1) n_blank++;
        chk("dark_data", (out_blank === 1'b1) ? 80'h0 : exp_dark, out_data);
      end else begin
        n_img++;
        chk("image_data", exp_img, out_data);
      end
    end
  end

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_addr = 9'h000;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    rolling_shutter = 1'b1;
    win_kernels = 8'h04;
    sync_dark_rows = 1'b0;
    dark_target = 10'h010;
    exp_img = '0;
    exp_dark = '0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    rd(`FILT_CFG_ADDR, 16'h0000);
    rd(`OFS_CTRL_ADDR, 16'h0000);
    rd(`ROW_CFG_ADDR, 16'h0008);
    rd(9'h000, 16'h0000);
    wr(`SHORT_ADDR, 16'hFFFF);
    rd(`SHORT_ADDR, 16'h0000);
    // Row count written while unsynced must not take effect
    wr(`ROW_CFG_ADDR, 16'h0002);
    wr(`OFS_CTRL_ADDR, 16'h000A);
    exp_img = cv(5, 1);
    frame(32, cv(20, 1), cv(0, 1), 1, 0);
    sync_dark_rows = 1'b1;
    wr(`OFS_CTRL_ADDR, 16'h040A);
    rd(`OFS_CTRL_ADDR, 16'h040A);
    exp_img = cv(0, 0);
    frame(8, cv(20, 1), cv(3, 0), 0, 0);
    rolling_shutter = 1'b0;
    wr(`OFS_CTRL_ADDR, 16'h0401);
    exp_img = cv(96, -1);
    frame(480, cv(20, 1), cv(100, 0), 0, 0);
    rd(`SHORT_ADDR, 16'h0000);
    exp_img = cv(86, -1);
    frame(480, cv(30, 1), cv(100, 0), 0, 0);
    wr(`OFS_CTRL_ADDR, 16'h03FF);
    frame(480, cv(40, 1), cv(100, 0), 0, 0);
    wr(`OFS_CTRL_ADDR, 16'h0001);
    exp_img = cv(76, -1);
    frame(480, cv(40, 1), cv(100, 0), 0, 0);
    rolling_shutter = 1'b1;
    wr(`OFS_CTRL_ADDR, 16'h0000);
    wr(`ROW_CFG_ADDR, 16'h0102);
    wr(`FILT_CFG_ADDR, 16'h0700);
    exp_img = cv(100, 0);
    frame(8, cv(20, 1), cv(100, 0), 0, 4);
    rd(`SHORT_ADDR, 16'h00FF);
    wr(`FILT_CFG_ADDR, 16'h0200);
    frame(8, cv(20, 1), cv(100, 0), 0, 4);
    rd(`SHORT_ADDR, 16'h0000);
    report_and_stop;
  end

  // Whole run needs about 2100 cycles
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
endmodule // tb
